// ---- rtl/sfh_handler.sv ----
// Feature-setting subcommand handler with an AXI4-Lite register slave.
// Assumes one clock, a synchronous reset and a host that polls busy.
// Notes on behaviour
// - Subcommand comes in features, command code EFh, parameter in count.
// - Unsupported or invalid subcommand or parameter ends with abort and error.
// - 8-bit transfers supported only when the card feature set is present.
// - With 8-bit mode on, data register uses only the low eight lines.
// - 02h enables write cache; 82h disables it and flushes before completion.
// - Subcommand 03h takes type from count bits 7:3, mode from 2:0.
// - Type 00000b default PIO, 00001b PIO, 00100b multiword DMA, 01000b Ultra DMA; others rejected.
// - Parameter all zeros selects default PIO mode.
// - Parameter 01h selects default PIO and drops flow control if possible.
// - Every mode below the highest supported in a class is accepted.
// - Flow control is provided whenever PIO mode is three or higher.
// - Selecting Ultra DMA clears multiword DMA, and the reverse.
// - Subcommand 05h adopts the power level taken from count.
// - Levels FEh, 81h-FDh, 80h, 02h-7Fh, 01h valid; FFh and 00h reserved.
// - Levels 80h and above forbid spinning down the media.
// - Subcommand 85h disables advanced power management.
// - 06h enables power-up in standby: ready but media not spun up.
// - Power-up-in-standby setting survives all resets.
// - 86h disables power-up in standby; factory default is disabled.
// - 0Ah selects card power mode 1, restored on software reset unless held, and always on hardware reset.
// - 8Ah drops to low-current power mode 0.
// - Mode 0 accepts identify, 0Ah, 8Ah, standby, sleep, check, diag, error.
// - Mode 0 aborts every other command needing more current.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sfh_handler
    import sfh_pkg::*;
#(
    parameter bit HAS_CARD_SET  = 1'b1,
    parameter bit CAN_DIS_IORDY = 1'b1
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        reset,
    // Non-volatile standby store.
    input  wire logic        nv_puis,
    output logic             nv_puis_we,
    output logic             nv_puis_val,
    // Software reset.
    input  wire logic        soft_reset,
    // Device controls.
    output logic             data_8bit,
    output logic             iordy_en,
    output logic             spin_down_ok,
    output logic             power_mode1,
    output logic             wcache_en,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef struct packed {
        sfh_state_t  state;
        logic [15:0] flush_cnt;
        logic        busy;
        logic        abort;
        logic        err;
        logic        done;
        logic        e8;
        logic        wc;
        logic        iordy;
        logic [2:0]  pio;
        logic        mdma_on;
        logic [2:0]  mdma;
        logic        udma_on;
        logic [2:0]  udma;
        logic        apm_on;
        logic [7:0]  apm;
        logic        puis;
        logic        pm1;
        logic        norev;
        logic        puis_we;
        logic        aw_got;
        logic [7:0]  aw;
        logic        w_got;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
        logic        sr1;
        logic        sr2;
        logic        nv1;
        logic        nv2;
        logic        loaded;
    } sfh_regs_t;

    sfh_regs_t r;
    sfh_regs_t next_r;

    // Commands allowed while in low-current mode 0.
    function automatic logic mode0_ok(input logic [7:0] c,
                                      input logic [7:0] f);
        case (c)
            CODE_IDENTIFY, CODE_STBY, CODE_STBY_IMM, CODE_SLEEP,
            CODE_CHKPWR, CODE_DIAG, CODE_EXTERR: mode0_ok = 1'b1;
            CODE_SETFEAT: mode0_ok = (f == SUB_PM1_EN) || (f == SUB_PM1_DIS);
            default:      mode0_ok = 1'b0;
        endcase
    endfunction : mode0_ok

    logic        wr_fire;
    logic [7:0]  c_code;
    logic [7:0]  c_feat;
    logic [7:0]  c_cnt;
    logic [4:0]  x_type;
    logic [2:0]  x_mode;

    always_comb begin
        next_r = r;
        next_r.puis_we = 1'b0;
        next_r.sr1 = soft_reset;
        next_r.sr2 = r.sr1;
        next_r.nv1 = nv_puis;
        next_r.nv2 = r.nv1;
        wr_fire = r.aw_got && r.w_got && !r.bv;
        c_code = r.wd[CMD_CODE_LSB +: 8];
        c_feat = r.wd[CMD_FEAT_LSB +: 8];
        c_cnt  = r.wd[CMD_CNT_LSB +: 8];
        x_type = c_cnt[7:3];
        x_mode = c_cnt[2:0];

        // Stored standby setting, taken once after reset.
        if (!r.loaded) begin
            next_r.loaded = 1'b1;
            next_r.puis = r.nv2;
        end

        // Software reset restores mode 1 unless reverting is held off.
        if (r.sr2 && !r.norev) begin
            next_r.pm1 = 1'b1;
        end

        // Write channel capture; either order is taken.
        if (s_axi_awvalid && !r.aw_got) begin
            next_r.aw_got = 1'b1;
            next_r.aw = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got) begin
            next_r.w_got = 1'b1;
            next_r.wd = s_axi_wdata;
            next_r.ws = s_axi_wstrb;
        end

        if (wr_fire) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bv = 1'b1;
            next_r.br = 2'b00;
            case (r.aw)
                OFF_CMD: begin
                    if (r.busy || r.ws != 4'hF) begin
                        // A command while busy, or partial write, is refused.
                        next_r.br = 2'b10;
                    end else begin
                        next_r.busy = 1'b1;
                        next_r.done = 1'b0;
                        next_r.abort = 1'b0;
                        next_r.err = 1'b0;
                        next_r.state = SFH_DONE;
                        if (!r.pm1 && !mode0_ok(c_code, c_feat)) begin
                            next_r.abort = 1'b1;
                        end else if (c_code == CODE_SETFEAT) begin
                            case (c_feat)
                                SUB_EN8, SUB_DIS8: begin
                                    if (HAS_CARD_SET) next_r.e8 = !c_feat[7];
                                    else next_r.abort = 1'b1;
                                end
                                SUB_WC_EN: next_r.wc = 1'b1;
                                SUB_WC_DIS: begin
                                    next_r.wc = 1'b0;
                                    next_r.state = SFH_FLUSH;
                                    next_r.flush_cnt = 16'(FLUSH_CYCLES);
                                end
                                SUB_XFER: begin
                                    case (x_type)
                                        XT_DEFAULT: begin
                                            if (x_mode == 3'h0) begin
                                                next_r.pio = 3'h0;
                                                next_r.iordy = 1'b1;
                                            end else if (x_mode == 3'h1 &&
                                                         CAN_DIS_IORDY) begin
                                                next_r.pio = 3'h0;
                                                next_r.iordy = 1'b0;
                                            end else begin
                                                next_r.abort = 1'b1;
                                            end
                                        end
                                        XT_PIO: begin
                                            if (x_mode <= PIO_MAX) begin
                                                next_r.pio = x_mode;
                                                next_r.iordy = 1'b1;
                                            end else begin
                                                next_r.abort = 1'b1;
                                            end
                                        end
                                        XT_MDMA: begin
                                            if (x_mode <= MDMA_MAX) begin
                                                next_r.mdma = x_mode;
                                                next_r.mdma_on = 1'b1;
                                                next_r.udma_on = 1'b0;
                                            end else begin
                                                next_r.abort = 1'b1;
                                            end
                                        end
                                        XT_UDMA: begin
                                            // Cable check is the host's job.
                                            if (x_mode <= UDMA_MAX) begin
                                                next_r.udma = x_mode;
                                                next_r.udma_on = 1'b1;
                                                next_r.mdma_on = 1'b0;
                                            end else begin
                                                next_r.abort = 1'b1;
                                            end
                                        end
                                        default: next_r.abort = 1'b1;
                                    endcase
                                end
                                SUB_APM_EN: begin
                                    if (c_cnt == APM_RSV_LO ||
                                        c_cnt == APM_RSV_HI) begin
                                        next_r.abort = 1'b1;
                                    end else begin
                                        next_r.apm = c_cnt;
                                        next_r.apm_on = 1'b1;
                                    end
                                end
                                SUB_APM_DIS: next_r.apm_on = 1'b0;
                                SUB_PUIS_EN: begin
                                    next_r.puis = 1'b1;
                                    next_r.puis_we = 1'b1;
                                end
                                SUB_PUIS_DIS: begin
                                    next_r.puis = 1'b0;
                                    next_r.puis_we = 1'b1;
                                end
                                SUB_PM1_EN:  next_r.pm1 = 1'b1;
                                SUB_PM1_DIS: next_r.pm1 = 1'b0;
                                SUB_NOREV:   next_r.norev = 1'b1;
                                SUB_REV:     next_r.norev = 1'b0;
                                default:     next_r.abort = 1'b1;
                            endcase
                        end
                    end
                end
                OFF_STATUS, OFF_SETTINGS, OFF_APM, OFF_FLUSH: next_r.br = 2'b00;
                default: next_r.br = 2'b10;
            endcase
        end
        if (r.bv && s_axi_bready) begin
            next_r.bv = 1'b0;
        end

        // Command engine: flush waits, then completion.
        case (r.state)
            SFH_IDLE: ;
            SFH_FLUSH: begin
                // Completion is held back until the flush has drained.
                if (r.flush_cnt <= 16'h0001) begin
                    next_r.state = SFH_DONE;
                end else begin
                    next_r.flush_cnt = r.flush_cnt - 16'h0001;
                end
            end
            SFH_DONE: begin
                next_r.state = SFH_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.err = r.abort;
            end
            default: next_r.state = SFH_IDLE;
        endcase

        // Read channel.
        if (s_axi_arvalid && !r.rv) begin
            next_r.rv = 1'b1;
            next_r.rr = 2'b00;
            case (s_axi_araddr)
                OFF_CMD:    next_r.rd = r.wd;
                OFF_STATUS: next_r.rd = {27'h0, r.state == SFH_FLUSH,
                                         r.err, r.abort, r.done, r.busy};
                OFF_SETTINGS: next_r.rd = {8'h0, r.norev, r.pm1, r.puis,
                                           r.apm_on, r.udma_on, r.udma,
                                           r.mdma_on, r.mdma, r.iordy,
                                           r.pio, 4'h0, r.wc, r.e8, 2'h0};
                OFF_APM:    next_r.rd = {24'h0, r.apm};
                OFF_FLUSH:  next_r.rd = {16'h0, r.flush_cnt};
                default: begin
                    next_r.rd = 32'h0;
                    next_r.rr = 2'b10;
                end
            endcase
        end
        if (r.rv && s_axi_rready) begin
            next_r.rv = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '0;
            r.state <= SFH_IDLE;
            r.pm1 <= 1'b1;
            r.iordy <= 1'b1;
            r.apm <= APM_RESET;
            // The store sync runs through reset, so the load sees it.
            r.nv1 <= next_r.nv1;
            r.nv2 <= next_r.nv2;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = !r.aw_got;
    assign s_axi_wready  = !r.w_got;
    assign s_axi_bvalid  = r.bv;
    assign s_axi_bresp   = r.br;
    assign s_axi_arready = !r.rv;
    assign s_axi_rvalid  = r.rv;
    assign s_axi_rdata   = r.rd;
    assign s_axi_rresp   = r.rr;

    assign data_8bit    = r.e8;
    assign iordy_en     = r.iordy || (r.pio >= PIO_IORDY);
    assign spin_down_ok = !r.apm_on || (r.apm < APM_NOSPIN);
    assign power_mode1  = r.pm1;
    assign wcache_en    = r.wc;
    assign nv_puis_we   = r.puis_we;
    assign nv_puis_val  = r.puis;

endmodule : sfh_handler
`default_nettype wire

// ---- rtl/sfh_pkg.sv ----
// Package for the feature-setting subcommand handler.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package sfh_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_CMD      = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_SETTINGS = 8'h08;
    localparam logic [7:0] OFF_APM      = 8'h0C;
    localparam logic [7:0] OFF_FLUSH    = 8'h10;

    // Command register fields.
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_FEAT_LSB = 8;
    localparam int CMD_CNT_LSB  = 16;

    // Command codes.
    localparam logic [7:0] CODE_SETFEAT  = 8'hEF;
    localparam logic [7:0] CODE_IDENTIFY = 8'hEC;
    localparam logic [7:0] CODE_STBY     = 8'hE2;
    localparam logic [7:0] CODE_STBY_IMM = 8'hE0;
    localparam logic [7:0] CODE_SLEEP    = 8'hE6;
    localparam logic [7:0] CODE_CHKPWR   = 8'hE5;
    localparam logic [7:0] CODE_DIAG     = 8'h90;
    localparam logic [7:0] CODE_EXTERR   = 8'h03;

    // Subcommands.
    localparam logic [7:0] SUB_EN8     = 8'h01;
    localparam logic [7:0] SUB_WC_EN   = 8'h02;
    localparam logic [7:0] SUB_XFER    = 8'h03;
    localparam logic [7:0] SUB_APM_EN  = 8'h05;
    localparam logic [7:0] SUB_PUIS_EN = 8'h06;
    localparam logic [7:0] SUB_PM1_EN  = 8'h0A;
    localparam logic [7:0] SUB_DIS8    = 8'h81;
    localparam logic [7:0] SUB_WC_DIS  = 8'h82;
    localparam logic [7:0] SUB_APM_DIS = 8'h85;
    localparam logic [7:0] SUB_PUIS_DIS= 8'h86;
    localparam logic [7:0] SUB_PM1_DIS = 8'h8A;
    localparam logic [7:0] SUB_NOREV   = 8'h66;
    localparam logic [7:0] SUB_REV     = 8'hCC;

    // Transfer type field values.
    localparam logic [4:0] XT_DEFAULT = 5'h00;
    localparam logic [4:0] XT_PIO     = 5'h01;
    localparam logic [4:0] XT_MDMA    = 5'h04;
    localparam logic [4:0] XT_UDMA    = 5'h08;

    // Power management level points.
    localparam logic [7:0] APM_RSV_LO  = 8'h00;
    localparam logic [7:0] APM_RSV_HI  = 8'hFF;
    localparam logic [7:0] APM_NOSPIN  = 8'h80;
    localparam logic [7:0] APM_RESET   = 8'hFE;

    // Highest modes supported, and the PIO mode from which flow control is forced on.
    localparam logic [2:0] PIO_MAX     = 3'h4;
    localparam logic [2:0] MDMA_MAX    = 3'h2;
    localparam logic [2:0] UDMA_MAX    = 3'h5;
    localparam logic [2:0] PIO_IORDY   = 3'h3;

    // Flush time and its cycle count at 125 MHz.
    localparam int FLUSH_NS     = 1000;
    localparam int CLK_NS       = 8;
    localparam int FLUSH_CYCLES = (FLUSH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        SFH_IDLE,
        SFH_FLUSH,
        SFH_DONE
    } sfh_state_t;

endpackage : sfh_pkg

// ---- testbench/set_features_subcommand_handler_tb_top.sv ----
// Bench for the subcommand handler.
// Assumes package, handler and store model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module set_features_subcommand_handler_tb_top;
    import sfh_pkg::*;
    logic        mclk, reset, soft_reset, nv_puis, nv_puis_we, nv_puis_val;
    logic        data_8bit, iordy_en, spin_down_ok, power_mode1, wcache_en;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, ok, kn, mon, uon;
    logic [2:0]  pio, mdma, udma, md;
    logic [4:0]  ty;
    logic [7:0]  al;
    // Ultra DMA 5 assumes an 80-conductor cable was confirmed.
    logic [7:0]  xm [12] = '{8'h0C, 8'h0D, 8'h01, 8'h00, 8'h0B, 8'h22,
                             8'h23, 8'h45, 8'h46, 8'h21, 8'h10, 8'h80};
    logic [7:0]  lv [6] = '{8'hFE, 8'h7F, 8'h01, 8'hFF, 8'h80, 8'h00};
    logic [7:0]  m0 [7] = '{CODE_IDENTIFY, CODE_STBY, CODE_STBY_IMM,
                            CODE_SLEEP, CODE_CHKPWR, CODE_DIAG, CODE_EXTERR};
    int          n_errors = 0, n_checks = 0, cyc = 0, t0;
    sfh_handler DUT (.*);
    sfh_nv_model u_nv (.*);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chk1
    // Ready is sampled mid-cycle, where it is settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic ta, tw;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge mclk);
            {ta, tw} = {s_axi_awready, s_axi_wready};
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !ta || s_axi_wvalid && !tw);
        do @(negedge mclk); while (!s_axi_bvalid);
        @(posedge mclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] dat);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(negedge mclk); while (!s_axi_arready);
        @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge mclk); while (!s_axi_rvalid);
        {dat, r} = {s_axi_rdata, s_axi_rresp};
        @(posedge mclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic cmd(input logic [7:0] code, feat, cnt, input logic ab);
        logic [31:0] s = 32'h1;
        wr(OFF_CMD, {8'h00, cnt, feat, code});
        while (s[0] !== 1'b0 || s[1] !== 1'b1) rd(OFF_STATUS, s);
        chk({30'h0, s[3:2]}, {30'h0, ab, ab});
    endtask : cmd
    task automatic rst(input logic hw);
        @(posedge mclk);
        if (hw) reset <= 1'b1;
        else soft_reset <= 1'b1;
        repeat (6) @(posedge mclk);
        {reset, soft_reset} <= 2'b00;
        repeat (3) @(posedge mclk);
    endtask : rst
    initial begin
        {soft_reset, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0F;
        {kn, mon, uon, pio, mdma, udma, al} = {3'b000, 9'h000, APM_RESET};
        rst(1'b1);
        rd(OFF_SETTINGS, d);
        chk(d & 32'h0070_000C, 32'h0040_0000);
        rd(OFF_APM, d);
        chk({24'h0, d[7:0]}, {24'h0, APM_RESET});
        rd(8'h14, d);
        chk({d[29:0], r}, 32'h2);
        cmd(CODE_SETFEAT, SUB_EN8, 8'h00, 1'b0);
        chk1(data_8bit, 1'b1);
        cmd(CODE_SETFEAT, SUB_DIS8, 8'h00, 1'b0);
        chk1(data_8bit, 1'b0);
        cmd(CODE_SETFEAT, 8'h55, 8'h00, 1'b1);
        cmd(CODE_SETFEAT, SUB_WC_EN, 8'h00, 1'b0);
        chk1(wcache_en, 1'b1);
        t0 = cyc;
        cmd(CODE_SETFEAT, SUB_WC_DIS, 8'h00, 1'b0);
        chk1(cyc - t0 > FLUSH_CYCLES, 1'b1);
        chk1(wcache_en, 1'b0);
        $display("test basic subcommands done");
        foreach (xm[i]) begin
            {ty, md} = xm[i];
            ok = (ty == XT_DEFAULT && md <= 3'h1) || (ty == XT_PIO && md <= PIO_MAX)
                || (ty == XT_MDMA && md <= MDMA_MAX) || (ty == XT_UDMA && md <= UDMA_MAX);
            cmd(CODE_SETFEAT, SUB_XFER, xm[i], !ok);
            if (ok) case (ty)
                XT_PIO: pio = md;
                XT_MDMA: {mon, uon, mdma, kn} = {2'b10, md, 1'b1};
                XT_UDMA: {mon, uon, udma, kn} = {2'b01, md, 1'b1};
                default: pio = 3'h0;
            endcase
            rd(OFF_SETTINGS, d);
            chk(d & {12'h0, {8{kn}}, 12'h700}, {12'h0, uon, udma, mon, mdma, 1'b0,
                pio, 8'h00} & {12'h0, {8{kn}}, 12'h700});
            if (xm[i] == 8'h01) chk1(iordy_en, 1'b0);
            if (ok && ty == XT_PIO && md >= PIO_IORDY) chk1(iordy_en, 1'b1);
        end
        $display("test transfer modes done");
        foreach (lv[i]) begin
            ok = lv[i] != APM_RSV_HI && lv[i] != APM_RSV_LO;
            cmd(CODE_SETFEAT, SUB_APM_EN, lv[i], !ok);
            if (ok) al = lv[i];
            rd(OFF_APM, d);
            chk({24'h0, d[7:0]}, {24'h0, al});
            chk1(spin_down_ok, al < APM_NOSPIN);
        end
        cmd(CODE_SETFEAT, SUB_APM_DIS, 8'h00, 1'b0);
        chk1(spin_down_ok, 1'b1);
        $display("test power levels done");
        cmd(CODE_SETFEAT, SUB_PUIS_EN, 8'h00, 1'b0);
        chk1(nv_puis_val, 1'b1);
        rst(1'b1);
        chk1(nv_puis_val, 1'b1);
        cmd(CODE_SETFEAT, SUB_PUIS_DIS, 8'h00, 1'b0);
        chk1(nv_puis_val, 1'b0);
        $display("test standby setting done");
        cmd(CODE_SETFEAT, SUB_PM1_DIS, 8'h00, 1'b0);
        chk1(power_mode1, 1'b0);
        foreach (m0[i]) cmd(m0[i], 8'h00, 8'h00, 1'b0);
        cmd(8'hC8, 8'h00, 8'h00, 1'b1);
        cmd(CODE_SETFEAT, SUB_WC_EN, 8'h00, 1'b1);
        cmd(CODE_SETFEAT, SUB_PM1_EN, 8'h00, 1'b0);
        chk1(power_mode1, 1'b1);
        cmd(CODE_SETFEAT, SUB_NOREV, 8'h00, 1'b0);
        cmd(CODE_SETFEAT, SUB_PM1_DIS, 8'h00, 1'b0);
        rst(1'b0);
        chk1(power_mode1, 1'b0);
        cmd(CODE_SETFEAT, SUB_PM1_EN, 8'h00, 1'b0);
        cmd(CODE_SETFEAT, SUB_REV, 8'h00, 1'b0);
        cmd(CODE_SETFEAT, SUB_PM1_DIS, 8'h00, 1'b0);
        rst(1'b0);
        chk1(power_mode1, 1'b1);
        $display("test card power modes done");
        final_report();
    end
endmodule : set_features_subcommand_handler_tb_top
`default_nettype wire

// ---- testbench/sfh_handler_sva.sv ----
// Port checker for the subcommand handler.
// Assumes it is bound to sfh_handler and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sfh_handler_sva
    import sfh_pkg::*;
(
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        reset,
    // Device side.
    input wire logic        nv_puis_we,
    input wire logic        nv_puis_val,
    input wire logic        data_8bit,
    input wire logic        wcache_en,
    input wire logic        power_mode1,
    // Register bus.
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [7:0] rd_addr;
    logic       set_rd;
    // Read data carries no address, so the last accepted one is kept.
    always_ff @(posedge mclk) begin
        if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    end
    assign set_rd = s_axi_rvalid && rd_addr == OFF_SETTINGS;
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_st_rd;
        s_axi_rvalid && rd_addr == OFF_STATUS;
    endsequence
    property p_b_time; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_time: assert property (p_b_time) else $error("write answer late");
    property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer repeats");
    property p_r_time; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_r_time: assert property (p_r_time) else $error("read answer late");
    property p_nv_pulse; nv_puis_we |=> !nv_puis_we; endproperty
    a_nv_pulse: assert property (p_nv_pulse) else $error("store strobe long");
    property p_abort; s_st_rd ##0 s_axi_rdata[1] |-> s_axi_rdata[3] == s_axi_rdata[2];
    endproperty
    a_abort: assert property (p_abort) else $error("abort without error");
    property p_iordy; set_rd && s_axi_rdata[10:8] >= PIO_IORDY |-> s_axi_rdata[11];
    endproperty
    a_iordy: assert property (p_iordy) else $error("fast mode lacks flow");
    property p_dma; set_rd |-> !(s_axi_rdata[19] && s_axi_rdata[15]); endproperty
    a_dma: assert property (p_dma) else $error("both DMA kinds on");
    property p_e8; set_rd |-> s_axi_rdata[2] == data_8bit; endproperty
    a_e8: assert property (p_e8) else $error("8-bit flag differs");
    property p_wc; set_rd |-> s_axi_rdata[3] == wcache_en; endproperty
    a_wc: assert property (p_wc) else $error("cache flag differs");
    property p_pm; set_rd |-> s_axi_rdata[22] == power_mode1; endproperty
    a_pm: assert property (p_pm) else $error("power mode differs");
    property p_puis; set_rd |-> s_axi_rdata[21] == nv_puis_val; endproperty
    a_puis: assert property (p_puis) else $error("standby flag differs");
endmodule : sfh_handler_sva
bind sfh_handler sfh_handler_sva u_sva (.*);
`default_nettype wire

// ---- testbench/sfh_nv_model.sv ----
// Model of the non-volatile store that holds the standby-at-power-up bit.
// Assumes the handler pulses its write strobe for one clock cycle.
`timescale 1ns/1ps
`default_nettype none
module sfh_nv_model (
    // Clock.
    input  wire logic mclk,
    // Store write from the handler.
    input  wire logic nv_puis_we,
    input  wire logic nv_puis_val,
    // Stored copy back to the handler.
    output logic      nv_puis
);
    // The store leaves the factory cleared.
    initial nv_puis = 1'b0;
    // No reset reaches the store, so the bit outlives every reset.
    always @(posedge mclk) begin
        if (nv_puis_we) nv_puis <= nv_puis_val;
    end
endmodule : sfh_nv_model
`default_nettype wire
